/* File: rtl/irq_priority_systick_defines.vh */
`ifndef IRQ_PRIORITY_SYSTICK_DEFINES_VH
`define IRQ_PRIORITY_SYSTICK_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_IRQ_ENABLE     8'h00
`define REG_IRQ_PEND       8'h04
`define REG_IRQ_CLRPEND    8'h08
`define REG_IRQ_MODE       8'h0C
`define REG_PRIO_LO        8'h10
`define REG_PRIO_HI        8'h14
`define REG_SYS_PRIO       8'h18
`define REG_SYS_CTRL       8'h1C
`define REG_TICK_CSR       8'h20
`define REG_TICK_RELOAD    8'h24
`define REG_TICK_CURRENT   8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SYSP_SVC_LSB       1
`define SYSP_PSV_LSB       3
`define SYSP_TICK_LSB      5
`define SCTL_PENDABLE_SERVICE_EXC_SET    0
`define SCTL_SLEEP_EXIT    1
`define SCTL_TICK_SET      2
`define SCTL_ACTIVE_LSB    8
`define SCTL_HANDLER       16
`define SCTL_SLEEPING      17
`define TCSR_ENABLE        0
`define TCSR_TICKINT       1
`define TCSR_FLAG          16

// ----------------------------------------------------------------
// vector numbers and ranks (lower rank is more urgent)
// ----------------------------------------------------------------
`define VEC_RESET          6'h01
`define VEC_NMI            6'h02
`define VEC_HARDFAULT      6'h03
`define VEC_SUPERVISOR_CALL_EXC         6'h0B
`define VEC_PENDABLE_SERVICE_EXC         6'h0E
`define VEC_SYSTICK        6'h0F
`define VEC_IRQ_BASE       6'h10
`define VEC_THREAD         6'h00
`define RANK_RESET         3'h0
`define RANK_NMI           3'h1
`define RANK_HARDFAULT     3'h2
`define RANK_CFG_BASE      3'h3
`define RANK_THREAD        3'h7
`define PRIO_RESET         2'h0

`endif

/* File: rtl/tick_down_counter.v */
`include "irq_priority_systick_defines.vh"

module tick_down_counter #(
  parameter WIDTH = 24
) (
  input  wire             clk_i,      // core clock
  input  wire             resetn_i,   // async reset, active low
  input  wire             enable_i,   // counting enabled
  input  wire [WIDTH-1:0] reload_i,   // reload value
  input  wire             cur_wr_i,   // any write clears count
  input  wire             csr_rd_i,   // status read clears flag
  output reg  [WIDTH-1:0] count_o,    // current count
  output reg              flag_o,     // count reached zero, sticky
  output wire             zero_evt_o  // pulse: counter arrives at zero
);

  // a transition to zero happens only when counting down from one
  assign zero_evt_o = enable_i && !cur_wr_i &&
                      (count_o == {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_o <= {WIDTH{1'b0}};
      flag_o  <= 1'b0;
    end
    else
    begin
      if (cur_wr_i)
        count_o <= {WIDTH{1'b0}};
      else if (enable_i)
      begin
        if (count_o == {WIDTH{1'b0}})
          count_o <= reload_i;
        else
          count_o <= count_o - {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (zero_evt_o)
        flag_o <= 1'b1;
      else if (csr_rd_i)
        flag_o <= 1'b0;
    end
  end

endmodule

/* File: rtl/nest_frame_stack.v */
`include "irq_priority_systick_defines.vh"

module nest_frame_stack #(
  parameter DEPTH = 8,
  parameter AW    = 3,
  parameter DW    = 9
) (
  input  wire          clk_i,     // core clock
  input  wire          resetn_i,  // async reset, active low
  input  wire          push_i,    // store a preempted frame
  input  wire          pop_i,     // discard top frame
  input  wire [DW-1:0] wdata_i,   // frame to store
  input  wire [DW-1:0] empty_i,   // value shown when empty
  output reg  [DW-1:0] top_o,     // registered top frame
  output reg  [AW:0]   depth_o    // frames held
);

  reg [DW-1:0] mem [0:DEPTH-1];
  // index of the frame under the top one, full width before the cut
  wire [AW:0]  below = depth_o - {{(AW-1){1'b0}}, 2'b10};

  // mem itself has no reset; top_o covers the empty case
  always @(posedge clk_i)
  begin
    if (push_i)
      mem[depth_o[AW-1:0]] <= wdata_i;
  end

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      depth_o <= {(AW+1){1'b0}};
      top_o   <= {DW{1'b0}};
    end
    else if (push_i)
    begin
      depth_o <= depth_o + {{AW{1'b0}}, 1'b1};
      top_o   <= wdata_i;
    end
    else if (pop_i && depth_o != {(AW+1){1'b0}})
    begin
      depth_o <= depth_o - {{AW{1'b0}}, 1'b1};
      if (depth_o == {{AW{1'b0}}, 1'b1})
        top_o <= empty_i;
      else
        top_o <= mem[below[AW-1:0]];
    end
    else if (depth_o == {(AW+1){1'b0}})
      top_o <= empty_i;
  end

endmodule

/* File: rtl/irq_priority_systick.v */
`include "irq_priority_systick_defines.vh"

// How it works
// - 32 lines, four priority levels each
// - strictly more urgent request preempts handler
// - priority 0 most urgent; resets to 0
// - reset, NMI, hard fault rank first
// - fixed vector numbers per exception
// - accepted vector fetched from table address
// - state saved on entry, restored on exit
// - pending at exit chains without restore
// - late urgent arrival replaces entry vector
// - each line level or pulse sensitive
// - separate unmaskable NMI input
// - 24-bit down counter, write clears
// - reload on edge after zero
// - flag set at zero, read clears
// - zero reload holds counter at zero
// - handler mode signalled during handlers
// - sleep entry and wake detection
module irq_priority_systick #(
  parameter NIRQ     = 32,
  parameter TW       = 24,
  parameter VEC_BASE = 32'h00000000
) (
  input  wire            clk_i,        // core clock, 25 MHz
  input  wire            resetn_i,     // async reset, active low
  input  wire            psel_i,       // apb select
  input  wire            penable_i,    // apb access phase
  input  wire            pwrite_i,     // apb write
  input  wire [7:0]      paddr_i,      // apb byte address
  input  wire [31:0]     pwdata_i,     // apb write data
  output wire            pready_o,     // apb ready
  output reg  [31:0]     prdata_o,     // apb read data
  output reg             pslverr_o,    // apb unmapped address
  input  wire [NIRQ-1:0] irq_i,        // peripheral lines, async
  input  wire            nmi_i,        // non-maskable line, async
  input  wire            hardfault_i,  // pulse from core
  input  wire            supervisor_call_exc_i,     // pulse from core
  input  wire            wfi_i,        // pulse: wait for interrupt
  input  wire            wfe_i,        // pulse: wait for event
  input  wire            event_i,      // pulse: event for wfe
  input  wire            entry_ack_i,  // pulse: handler starts
  input  wire            exc_return_i, // pulse: handler ended
  output reg             entry_req_o,  // level: dispatch pending
  output reg             stack_req_o,  // save state during entry
  output reg  [5:0]      vector_o,     // vector to dispatch
  output reg  [31:0]     fetch_addr_o, // vector table address
  output reg             unstack_o,    // pulse: restore state
  output reg             handler_mode_o, // handler mode
  output reg  [5:0]      active_vec_o, // running vector
  output reg             sleeping_o    // core may stop clocks
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [2:0] cfg_rank;
    input [1:0] p;
    begin
      cfg_rank = `RANK_CFG_BASE + {1'b0, p};
    end
  endfunction

  function [31:0] table_addr;
    input [5:0] v;
    begin
      table_addr = VEC_BASE + {24'h000000, v, 2'b00};
    end
  endfunction

  localparam ST_RUN   = 2'b01;
  localparam ST_ENTRY = 2'b10;

  // ----------------------------------------------------------------
  // registers and input synchronisers
  // ----------------------------------------------------------------
  reg  [NIRQ-1:0]   irq_meta, irq_sync, irq_prev;
  reg               nmi_meta, nmi_sync, nmi_prev;
  reg  [NIRQ-1:0]   irq_enable, irq_pulse_mode, irq_pend;
  reg  [2*NIRQ-1:0] irq_prio;
  reg  [5:0]        sys_prio;
  reg               nmi_pend, hf_pend, svc_pend, psv_pend, tick_pend;
  reg               sleep_on_exit, wfe_mode;
  reg               tick_en, tick_int;
  reg  [TW-1:0]     tick_reload;
  reg  [1:0]        state;
  reg               tail;
  reg  [2:0]        cur_rank;
  reg  [5:0]        best_vec;
  reg  [2:0]        best_rank;
  reg  [2:0]        best_rank_of_vec;
  reg  [31:0]       rd_mux;
  reg               rd_err;
  integer           i, j;

  wire        wr_acc = psel_i && penable_i && pwrite_i;
  wire        rd_acc = psel_i && penable_i && !pwrite_i;
  wire [TW-1:0] tick_count;
  wire        tick_flag, tick_zero;
  wire [8:0]  top_frame;
  wire [3:0]  depth;
  wire        accept = (state == ST_ENTRY) && entry_ack_i;
  wire        ret    = (state == ST_RUN) && exc_return_i &&
                       handler_mode_o;
  wire        chain  = ret && (best_rank < top_frame[2:0]);
  wire        push   = accept && !tail;
  wire        pop    = ret && !chain;

  // ----------------------------------------------------------------
  // pending logic
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_meta <= {NIRQ{1'b0}};
      irq_sync <= {NIRQ{1'b0}};
      irq_prev <= {NIRQ{1'b0}};
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
      irq_pend <= {NIRQ{1'b0}};
      nmi_pend <= 1'b0;
      hf_pend  <= 1'b0;
      svc_pend <= 1'b0;
      psv_pend <= 1'b0;
      tick_pend <= 1'b0;
    end
    else
    begin
      irq_meta <= irq_i;
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
      nmi_meta <= nmi_i;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
      for (i = 0; i < NIRQ; i = i + 1)
      begin
        if (irq_pulse_mode[i] ? (irq_sync[i] && !irq_prev[i])
                              : irq_sync[i])
          irq_pend[i] <= 1'b1;
        else if ((accept && vector_o == `VEC_IRQ_BASE + i[5:0]) ||
                 (wr_acc && paddr_i == `REG_IRQ_CLRPEND &&
                  pwdata_i[i]))
          irq_pend[i] <= 1'b0;
      end
      if (nmi_sync && !nmi_prev)
        nmi_pend <= 1'b1;
      else if (accept && vector_o == `VEC_NMI)
        nmi_pend <= 1'b0;
      if (hardfault_i)
        hf_pend <= 1'b1;
      else if (accept && vector_o == `VEC_HARDFAULT)
        hf_pend <= 1'b0;
      if (supervisor_call_exc_i)
        svc_pend <= 1'b1;
      else if (accept && vector_o == `VEC_SUPERVISOR_CALL_EXC)
        svc_pend <= 1'b0;
      if (wr_acc && paddr_i == `REG_SYS_CTRL &&
          pwdata_i[`SCTL_PENDABLE_SERVICE_EXC_SET])
        psv_pend <= 1'b1;
      else if (accept && vector_o == `VEC_PENDABLE_SERVICE_EXC)
        psv_pend <= 1'b0;
      if ((tick_zero && tick_int) || (wr_acc &&
          paddr_i == `REG_SYS_CTRL && pwdata_i[`SCTL_TICK_SET]))
        tick_pend <= 1'b1;
      else if (accept && vector_o == `VEC_SYSTICK)
        tick_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // candidates are scanned in rising vector order and only a strictly
  // better rank replaces the holder, so ties go to the lower vector
  always @*
  begin
    best_vec  = `VEC_THREAD;
    best_rank = `RANK_THREAD;
    if (nmi_pend)
    begin
      best_vec  = `VEC_NMI;
      best_rank = `RANK_NMI;
    end
    else if (hf_pend)
    begin
      best_vec  = `VEC_HARDFAULT;
      best_rank = `RANK_HARDFAULT;
    end
    if (svc_pend && cfg_rank(sys_prio[`SYSP_SVC_LSB -: 2]) < best_rank)
    begin
      best_vec  = `VEC_SUPERVISOR_CALL_EXC;
      best_rank = cfg_rank(sys_prio[`SYSP_SVC_LSB -: 2]);
    end
    if (psv_pend && cfg_rank(sys_prio[`SYSP_PSV_LSB -: 2]) < best_rank)
    begin
      best_vec  = `VEC_PENDABLE_SERVICE_EXC;
      best_rank = cfg_rank(sys_prio[`SYSP_PSV_LSB -: 2]);
    end
    if (tick_pend && cfg_rank(sys_prio[`SYSP_TICK_LSB -: 2]) < best_rank)
    begin
      best_vec  = `VEC_SYSTICK;
      best_rank = cfg_rank(sys_prio[`SYSP_TICK_LSB -: 2]);
    end
    for (j = 0; j < NIRQ; j = j + 1)
    begin
      if (irq_pend[j] && irq_enable[j] &&
          cfg_rank(irq_prio[2*j +: 2]) < best_rank)
      begin
        best_vec  = `VEC_IRQ_BASE + j[5:0];
        best_rank = cfg_rank(irq_prio[2*j +: 2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // dispatch sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state          <= ST_RUN;
      tail           <= 1'b0;
      cur_rank       <= `RANK_THREAD;
      entry_req_o    <= 1'b0;
      stack_req_o    <= 1'b0;
      vector_o       <= `VEC_THREAD;
      fetch_addr_o   <= 32'h00000000;
      unstack_o      <= 1'b0;
      handler_mode_o <= 1'b0;
      active_vec_o   <= `VEC_THREAD;
    end
    else
    begin
      unstack_o <= 1'b0;
      case (state)
        ST_RUN:
        begin
          if (chain)
          begin
            state        <= ST_ENTRY;
            tail         <= 1'b1;
            cur_rank     <= top_frame[2:0];
            entry_req_o  <= 1'b1;
            stack_req_o  <= 1'b0;
            vector_o     <= best_vec;
            fetch_addr_o <= table_addr(best_vec);
          end
          else if (pop)
          begin
            unstack_o      <= 1'b1;
            cur_rank       <= top_frame[2:0];
            active_vec_o   <= top_frame[8:3];
            handler_mode_o <= (depth != 4'h1);
          end
          else if (best_rank < cur_rank)
          begin
            state        <= ST_ENTRY;
            tail         <= 1'b0;
            entry_req_o  <= 1'b1;
            stack_req_o  <= 1'b1;
            vector_o     <= best_vec;
            fetch_addr_o <= table_addr(best_vec);
          end
        end
        ST_ENTRY:
        begin
          if (entry_ack_i)
          begin
            state          <= ST_RUN;
            entry_req_o    <= 1'b0;
            stack_req_o    <= 1'b0;
            cur_rank       <= best_rank_of_vec;
            active_vec_o   <= vector_o;
            handler_mode_o <= 1'b1;
          end
          else if (best_rank < cur_rank)
          begin
            vector_o     <= best_vec;
            fetch_addr_o <= table_addr(best_vec);
          end
        end
        default:
        begin
          state       <= ST_RUN;
          entry_req_o <= 1'b0;
        end
      endcase
    end
  end

  // rank of the vector being entered, held beside it
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      best_rank_of_vec <= `RANK_THREAD;
    else if ((state == ST_RUN && (chain || (!pop &&
             best_rank < cur_rank))) ||
             (state == ST_ENTRY && !entry_ack_i && best_rank < cur_rank))
      best_rank_of_vec <= best_rank;
  end

  nest_frame_stack #(
    .DEPTH (8),
    .AW    (3),
    .DW    (9)
  ) u_frames (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .push_i   (push),
    .pop_i    (pop),
    .wdata_i  ({active_vec_o, cur_rank}),
    .empty_i  ({`VEC_THREAD, `RANK_THREAD}),
    .top_o    (top_frame),
    .depth_o  (depth)
  );

  // ----------------------------------------------------------------
  // sleep and wake detection
  // ----------------------------------------------------------------
  // the detector looks at pending state and, after wfe, at event_i; it is
  // clocked by clk_i, so it stops working when the core stops that clock
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sleeping_o <= 1'b0;
      wfe_mode   <= 1'b0;
    end
    else if (sleeping_o && (best_rank < cur_rank ||
             (wfe_mode && event_i)))
      sleeping_o <= 1'b0;
    else if (wfi_i || wfe_i || (pop && sleep_on_exit &&
             depth == 4'h1 && !(best_rank < `RANK_THREAD)))
    begin
      sleeping_o <= 1'b1;
      wfe_mode   <= wfe_i;
    end
  end

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign pready_o = 1'b1;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_enable     <= {NIRQ{1'b0}};
      irq_pulse_mode <= {NIRQ{1'b0}};
      irq_prio       <= {NIRQ{`PRIO_RESET}};
      sys_prio       <= {3{`PRIO_RESET}};
      sleep_on_exit  <= 1'b0;
      tick_en        <= 1'b0;
      tick_int       <= 1'b0;
      tick_reload    <= {TW{1'b0}};
    end
    else if (wr_acc)
    begin
      case (paddr_i)
        `REG_IRQ_ENABLE: irq_enable     <= pwdata_i[NIRQ-1:0];
        `REG_IRQ_MODE:   irq_pulse_mode <= pwdata_i[NIRQ-1:0];
        `REG_PRIO_LO:    irq_prio[31:0]  <= pwdata_i;
        `REG_PRIO_HI:    irq_prio[63:32] <= pwdata_i;
        `REG_SYS_PRIO:   sys_prio       <= pwdata_i[5:0];
        `REG_SYS_CTRL:   sleep_on_exit  <= pwdata_i[`SCTL_SLEEP_EXIT];
        `REG_TICK_CSR:
        begin
          tick_en  <= pwdata_i[`TCSR_ENABLE];
          tick_int <= pwdata_i[`TCSR_TICKINT];
        end
        `REG_TICK_RELOAD: tick_reload <= pwdata_i[TW-1:0];
        default:          tick_en     <= tick_en;
      endcase
    end
  end

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr_i)
      `REG_IRQ_ENABLE:  rd_mux = irq_enable;
      `REG_IRQ_PEND:    rd_mux = irq_pend;
      `REG_IRQ_CLRPEND: rd_mux = irq_pend;
      `REG_IRQ_MODE:    rd_mux = irq_pulse_mode;
      `REG_PRIO_LO:     rd_mux = irq_prio[31:0];
      `REG_PRIO_HI:     rd_mux = irq_prio[63:32];
      `REG_SYS_PRIO:    rd_mux = {26'h0000000, sys_prio};
      `REG_SYS_CTRL:
        rd_mux = {14'h0000, sleeping_o, handler_mode_o, 2'h0,
                  active_vec_o, 6'h00, sleep_on_exit, psv_pend};
      `REG_TICK_CSR:
        rd_mux = {15'h0000, tick_flag, 14'h0000, tick_int, tick_en};
      `REG_TICK_RELOAD: rd_mux = {8'h00, tick_reload};
      `REG_TICK_CURRENT: rd_mux = {8'h00, tick_count};
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_o  <= pwrite_i ? 32'h00000000 : rd_mux;
      pslverr_o <= rd_err;
    end
  end

  // ----------------------------------------------------------------
  // tick timer
  // ----------------------------------------------------------------
  tick_down_counter #(
    .WIDTH (TW)
  ) u_tick (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .enable_i   (tick_en),
    .reload_i   (tick_reload),
    .cur_wr_i   (wr_acc && paddr_i == `REG_TICK_CURRENT),
    .csr_rd_i   (rd_acc && paddr_i == `REG_TICK_CSR),
    .count_o    (tick_count),
    .flag_o     (tick_flag),
    .zero_evt_o (tick_zero)
  );

endmodule

/* File: bench/irq_priority_systick_properties.sv */
module irq_priority_systick_checker #(
  parameter VEC_BASE = 32'h00000000
) (
  input logic        clk_i,          // clock
  input logic        resetn_i,       // reset
  input logic        nmi_i,          // nmi line
  input logic        entry_ack_i,    // entry done
  input logic        exc_return_i,   // handler end
  input logic        entry_req_o,    // dispatch
  input logic        stack_req_o,    // new nest
  input logic [5:0]  vector_o,       // vector
  input logic [31:0] fetch_addr_o,   // table addr
  input logic        unstack_o,      // restore
  input logic        handler_mode_o, // handler
  input logic [5:0]  active_vec_o    // running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_fetch_addr: assert property (
    entry_req_o |-> fetch_addr_o == VEC_BASE + {vector_o, 2'b00})
    else $error("bad fetch address");
  chk_vector_legal: assert property (
    entry_req_o |-> vector_o inside {6'h02, 6'h03, 6'h0B, 6'h0E,
                                     6'h0F, [6'h10:6'h2F]})
    else $error("illegal vector");
  chk_entry_holds: assert property (
    entry_req_o && !entry_ack_i |=> entry_req_o)
    else $error("entry dropped");
  chk_handler_mode: assert property (
    entry_req_o && entry_ack_i |=>
      handler_mode_o && active_vec_o == $past(vector_o))
    else $error("handler mode wrong");
  chk_unstack_cause: assert property (
    unstack_o |-> $past(exc_return_i)) else $error("stray restore");
  chk_unstack_pulse: assert property (
    unstack_o |=> !unstack_o) else $error("restore too long");
  chk_thread_stacks: assert property (
    entry_req_o && !handler_mode_o |-> stack_req_o)
    else $error("no state save");
  chk_nmi_entry: assert property (
    $rose(nmi_i) && active_vec_o != 6'h02 |->
      ##[1:8] entry_req_o && vector_o == 6'h02)
    else $error("nmi not taken");
endmodule

bind irq_priority_systick irq_priority_systick_checker #(
  .VEC_BASE(VEC_BASE)
) u_chk (.clk_i, .resetn_i, .nmi_i, .entry_ack_i, .exc_return_i,
  .entry_req_o, .stack_req_o, .vector_o, .fetch_addr_o, .unstack_o,
  .handler_mode_o, .active_vec_o);

/* File: bench/core_partner_model.sv */
module core_partner_model #(
  parameter RUN = 60
) (
  input  logic       clk_i,       // core clock
  input  logic       resetn_i,    // reset, low
  input  logic       entry_req_i, // dispatch
  input  logic [7:0] ack_dly_i,   // ack delay
  output logic       entry_ack_o, // handler starts
  output logic       exc_return_o // handler ends
);
  timeunit 1ns;
  timeprecision 1ns;
  int wt;
  int left[$];
  // each nested handler keeps its own remaining run time
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      entry_ack_o <= 1'b0;
      exc_return_o <= 1'b0;
      wt = 0;
      left.delete();
    end
    else
    begin
      entry_ack_o <= 1'b0;
      exc_return_o <= 1'b0;
      if (entry_req_i && !entry_ack_o)
      begin
        wt = wt + 1;
        if (wt > ack_dly_i)
        begin
          entry_ack_o <= 1'b1;
          wt = 0;
          left.push_back(RUN);
        end
      end
      else if (left.size() > 0 && !exc_return_o)
      begin
        if (left[$] == 0)
        begin
          exc_return_o <= 1'b1;
          void'(left.pop_back());
        end
        else
          left[$] = left[$] - 1;
      end
    end
endmodule

/* File: bench/irq_priority_systick_bench.sv */
`include "irq_priority_systick_defines.vh"
module irq_priority_systick_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0;
  logic        penable_i = 1'b0, pwrite_i = 1'b0, nmi_i = 1'b0;
  logic        pready_o, pslverr_o, entry_req_o, stack_req_o, unstack_o;
  logic        handler_mode_o, sleeping_o, entry_ack_i, exc_return_i;
  logic        hf = 1'b0, svc = 1'b0, wfi = 1'b0, wfe = 1'b0, ev = 1'b0;
  logic [7:0]  paddr_i = 8'h00, ack_dly = 8'h00;
  logic [31:0] pwdata_i = 32'h0, irq_i = 32'h0, prdata_o, fetch_addr_o;
  logic [5:0]  vector_o, active_vec_o;
  logic [63:0] pr;
  logic [32:0] rq[$];
  logic [6:0]  vq[$];
  int          seed = 50, miscompares = 0, num_checks = 0, a, b, n;
  irq_priority_systick dut (.clk_i, .resetn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o,
    .irq_i, .nmi_i, .hardfault_i(hf), .supervisor_call_exc_i(svc), .wfi_i(wfi),
    .wfe_i(wfe), .event_i(ev), .entry_ack_i, .exc_return_i,
    .entry_req_o, .stack_req_o, .vector_o, .fetch_addr_o, .unstack_o,
    .handler_mode_o, .active_vec_o, .sleeping_o);
  core_partner_model core (.clk_i, .resetn_i, .entry_req_i(entry_req_o),
    .ack_dly_i(ack_dly), .entry_ack_o(entry_ack_i),
    .exc_return_o(exc_return_i));
  always #20 clk_i = ~clk_i;
  task check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  always @(posedge clk_i)
  begin
    if (psel_i && penable_i && !pwrite_i)
      check({pslverr_o, prdata_o}, rq.pop_front());
    if (entry_req_o === 1'b1 && entry_ack_i === 1'b1)
      check({26'h0, stack_req_o, vector_o},
            {26'h0, vq.pop_front()});
  end
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] ad, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask
  task pulse(input logic [31:0] l, input logic m);
    irq_i <= l;
    nmi_i <= m;
    @(posedge clk_i);
    irq_i <= 32'h0;
    nmi_i <= 1'b0;
  endtask
  // 3F waits for a request, 00 for idle, else for that running vector
  task wait_til(input logic [5:0] v);
    n = 0;
    while (n < 3000 && (v == 6'h3F ? entry_req_o !== 1'b1 :
           v != 6'h00 ? active_vec_o !== v : (vq.size() > 0 ||
           entry_req_o !== 1'b0 || handler_mode_o !== 1'b0)))
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 3000)
      miscompares++;
  endtask
  task final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(`REG_PRIO_LO, 33'h0);
    rd(8'h3C, 33'h100000000);
    apb(1'b1, `REG_IRQ_MODE, 32'hFFFFFFFF);
    apb(1'b1, `REG_IRQ_ENABLE, 32'hFFFFFFFF);
    repeat (4)
    begin
      pr = {$random(seed), $random(seed)};
      apb(1'b1, `REG_PRIO_LO, pr[31:0]);
      apb(1'b1, `REG_PRIO_HI, pr[63:32]);
      rd(`REG_PRIO_HI, {1'b0, pr[63:32]});
      a = {$random(seed)} % 32;
      b = (a + 1 + {$random(seed)} % 31) % 32;
      n = pr[2*b+:2] < pr[2*a+:2] || (pr[2*b+:2] == pr[2*a+:2] && b < a);
      vq.push_back({1'b1, 6'h10 + (n ? b[5:0] : a[5:0])});
      vq.push_back({1'b0, 6'h10 + (n ? a[5:0] : b[5:0])});
      pulse((32'h1 << a) | (32'h1 << b), 1'b0);
      wait_til(6'h00);
    end
    apb(1'b1, `REG_PRIO_LO, 32'hFFFFFFF3);
    ack_dly <= 8'h0A;
    vq.push_back(7'h51);
    vq.push_back(7'h10);
    pulse(32'h1, 1'b0);
    wait_til(6'h3F);
    pulse(32'h2, 1'b0);
    wait_til(6'h00);
    ack_dly <= 8'h00;
    vq.push_back(7'h50);
    vq.push_back(7'h51);
    vq.push_back(7'h42);
    pulse(32'h1, 1'b0);
    wait_til(6'h10);
    pulse(32'h2, 1'b0);
    wait_til(6'h11);
    pulse(32'h0, 1'b1);
    wait_til(6'h00);
    apb(1'b1, `REG_TICK_RELOAD, 32'h0);
    apb(1'b1, `REG_TICK_CURRENT, 32'h5);
    apb(1'b1, `REG_TICK_CSR, 32'h1);
    rd(`REG_TICK_CURRENT, 33'h0);
    apb(1'b1, `REG_TICK_RELOAD, 32'hFFFFFFFF);
    rd(`REG_TICK_RELOAD, 33'hFFFFFF);
    apb(1'b1, `REG_TICK_RELOAD, 32'hC8);
    apb(1'b1, `REG_TICK_CURRENT, 32'h0);
    repeat (250) @(posedge clk_i);
    rd(`REG_TICK_CSR, 33'h10001);
    rd(`REG_TICK_CSR, 33'h1);
    vq.push_back(7'h4F);
    apb(1'b1, `REG_TICK_CSR, 32'h3);
    wait_til(6'h0F);
    apb(1'b1, `REG_TICK_CSR, 32'h0);
    apb(1'b1, `REG_TICK_CURRENT, $random(seed));
    rd(`REG_TICK_CURRENT, 33'h0);
    wait_til(6'h00);
    wfi <= 1'b1;
    @(posedge clk_i);
    wfi <= 1'b0;
    rd(`REG_SYS_CTRL, 33'h20000);
    vq.push_back(7'h4E);
    apb(1'b1, `REG_SYS_CTRL, 32'h1);
    wait_til(6'h0E);
    rd(`REG_SYS_CTRL, 33'h10E00);
    vq.push_back(7'h43);
    vq.push_back(7'h0B);
    hf <= 1'b1;
    svc <= 1'b1;
    @(posedge clk_i);
    hf <= 1'b0;
    svc <= 1'b0;
    wait_til(6'h00);
    wfe <= 1'b1;
    @(posedge clk_i);
    wfe <= 1'b0;
    rd(`REG_SYS_CTRL, 33'h20000);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    rd(`REG_SYS_CTRL, 33'h0);
    final_report;
  end
endmodule
